// ---- hdl/rst_pkg.sv ----
// Purpose : shared constants for the reset sequencer and startup timer
// Assumes : 100 MHz core clock, avalon-mm register access
// Notes   : register offsets are byte addresses of aligned 32-bit words
`default_nettype none
package rst_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned STARTUP_DELAY_MS  = 18;
  localparam int unsigned STARTUP_DELAY_CYC = STARTUP_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned CLKOUT_DIV        = 4;
  // ==========================================================
  // register map
  localparam logic [7:0] OFF_STATUS   = 8'h0C;  // index 3
  localparam logic [7:0] OFF_PC_LOW   = 8'h08;  // index 2
  localparam logic [7:0] OFF_DIR      = 8'h20;
  localparam logic [7:0] OFF_OPTION   = 8'h24;
  localparam logic [7:0] OFF_POINTER  = 8'h28;
  localparam logic [7:0] OFF_CTRL     = 8'h30;
  localparam logic [7:0] OFF_CAUSE    = 8'h34;
  localparam int unsigned STATUS_IDX  = 3;
  localparam int unsigned PC_LOW_IDX  = 2;
  // ==========================================================
  // field positions and reset values
  localparam int unsigned BIT_TIMEOUT   = 4;
  localparam int unsigned BIT_POWERDOWN = 3;
  localparam logic [7:0] PC_LOW_RST    = 8'hFF;
  localparam logic [7:0] DIR_RST       = 8'hFF;
  localparam logic [5:0] OPTION_RST    = 6'h3F;
  localparam logic [7:0] POINTER_TOP   = 8'h80;
  localparam logic [7:0] STATUS_POR    = 8'h18;
  localparam logic [7:0] STATUS_LOW3   = 8'h07;
  localparam logic [7:0] STATUS_LOW5   = 8'h1F;
  // cause codes as reported in the cause register
  typedef enum logic [4:0] {
    CAUSE_POR       = 5'b0_0001,
    CAUSE_PIN       = 5'b0_0010,
    CAUSE_PIN_WAKE  = 5'b0_0100,
    CAUSE_WDOG      = 5'b0_1000,
    CAUSE_WDOG_WAKE = 5'b1_0000
  } rst_cause_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_TIME = 3'b010,
    ST_RUN  = 3'b100
  } rst_state_t;
endpackage : rst_pkg
`default_nettype wire

// ---- hdl/rst_seq.sv ----
// Purpose : reset latch, startup delay timer, cause flags and reset values
// Assumes : power-on event, pin and watchdog inputs arrive asynchronously
// Notes   : the startup timer runs from its own rc clock, sampled here
//
// Design decision made here: the Avalon-MM slave port.
`default_nettype none
module rst_seq #(
  parameter int unsigned STARTUP_COUNT = rst_pkg::STARTUP_DELAY_CYC
) (
  input  wire  logic        clk,
  input  wire  logic        srst,
  input  wire  logic        power_up_event,
  input  wire  logic        supply_falling,
  input  wire  logic        external_reset_pin_n,
  input  wire  logic        watchdog_timeout,
  input  wire  logic        timer_rc_clk,
  input  wire  logic        osc_clk_in,
  input  wire  logic        resistor_capacitor_osc_mode,
  input  wire  logic        sleep_instr,
  input  wire  logic        clear_watchdog_instr,
  output logic              clock_output_pin,
  output logic              core_reset,
  output logic              osc_driver_on,
  output logic [7:0]        program_counter_low,
  output logic [7:0]        core_status,
  output logic [7:0]        port_direction_reg,
  output logic [5:0]        option_reg,
  output logic [7:0]        indirect_pointer_reg,
  output logic              startup_delay_timer_active,
  input  wire  logic [7:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [31:0] avs_writedata,
  input  wire  logic [3:0]  avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest
);
  import rst_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [1:0] pin_s_reg, wd_s_reg, por_s_reg, rc_s_reg, osc_s_reg;
  logic       wd_d_reg, por_d_reg, rc_d_reg, osc_d_reg, pin_d_reg;
  always_ff @(posedge clk) begin
    pin_s_reg <= {pin_s_reg[0], external_reset_pin_n};
    wd_s_reg  <= {wd_s_reg[0], watchdog_timeout};
    por_s_reg <= {por_s_reg[0], power_up_event};
    rc_s_reg  <= {rc_s_reg[0], timer_rc_clk};
    osc_s_reg <= {osc_s_reg[0], osc_clk_in};
    pin_d_reg <= pin_s_reg[1];
    wd_d_reg  <= wd_s_reg[1];
    por_d_reg <= por_s_reg[1];
    rc_d_reg  <= rc_s_reg[1];
    osc_d_reg <= osc_s_reg[1];
  end

  wire pin_high  = pin_s_reg[1];
  wire pin_fall  = pin_d_reg & ~pin_s_reg[1];
  wire wd_rise   = wd_s_reg[1] & ~wd_d_reg;
  // power-up acts on its rising edge only; a falling supply is ignored
  wire por_rise  = por_s_reg[1] & ~por_d_reg;
  wire rc_tick   = rc_s_reg[1] & ~rc_d_reg;
  wire osc_tick  = osc_s_reg[1] & ~osc_d_reg;
  wire unused_ok = supply_falling;

  // ==========================================================
  // sleep and cause decode
  logic asleep_reg;
  wire  any_reset = srst | por_rise | pin_fall | wd_rise;
  // wake from sleep is a reset like any other, never a resume
  wire  cause_por       = srst | por_rise;
  wire  cause_pin       = ~cause_por & pin_fall & ~asleep_reg;
  wire  cause_pin_wake  = ~cause_por & pin_fall & asleep_reg;
  wire  cause_wdog      = ~cause_por & ~pin_fall & wd_rise & ~asleep_reg;
  wire  cause_wdog_wake = ~cause_por & ~pin_fall & wd_rise & asleep_reg;

  always_ff @(posedge clk) begin
    if (any_reset) begin
      asleep_reg <= 1'b0;
    end else if (sleep_instr & ~core_reset) begin
      asleep_reg <= 1'b1;
    end
  end
  // oscillator driver off while asleep
  assign osc_driver_on = ~asleep_reg;

  // ==========================================================
  // reset latch and startup delay timer
  rst_state_t state_reg, state_next;
  logic [31:0] count_reg;
  wire timer_done = (count_reg >= STARTUP_COUNT - 1) & rc_tick;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: if (pin_high) state_next = ST_TIME;
      ST_TIME: begin
        if (!pin_high)       state_next = ST_HOLD;
        else if (timer_done) state_next = ST_RUN;
      end
      ST_RUN:  state_next = ST_RUN;
      default: state_next = ST_HOLD;
    endcase
    // latch set on power-up, pin or watchdog restarts timer
    if (any_reset) state_next = ST_HOLD;
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
    // counts edges of its own rc clock, cleared on any reset
    if (state_next != ST_TIME || state_reg != ST_TIME) begin
      count_reg <= 32'h0000_0000;
    end else if (rc_tick) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
    // release lands on one main clock edge for the whole core
    core_reset <= (state_next != ST_RUN);
  end
  assign startup_delay_timer_active = (state_reg == ST_TIME);

  // ==========================================================
  // clock output in rc mode
  logic [1:0] div_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      div_reg          <= 2'b00;
      clock_output_pin <= 1'b0;
    end else begin
      if (osc_tick) begin
        div_reg <= div_reg + 2'b01;
      end
      // one output period per four oscillator periods
      clock_output_pin <= resistor_capacitor_osc_mode & div_reg[1];
    end
  end

  // ==========================================================
  // special registers
  logic [7:0] status_next;
  logic [4:0] cause_reg;
  wire  bus_wr    = avs_write & avs_byteenable[0] & ~core_reset;
  wire  wr_status = bus_wr & (avs_address == OFF_STATUS);
  wire  wr_pc_low = bus_wr & (avs_address == OFF_PC_LOW);
  wire  wr_dir    = bus_wr & (avs_address == OFF_DIR);
  wire  wr_opt    = bus_wr & (avs_address == OFF_OPTION);
  wire  wr_ptr    = bus_wr & (avs_address == OFF_POINTER);
  wire  wr_ctrl   = bus_wr & (avs_address == OFF_CTRL);
  wire  sleep_ev  = ~core_reset & (sleep_instr | (wr_ctrl & avs_writedata[0]));
  wire  clrwd_ev  = ~core_reset & (clear_watchdog_instr | (wr_ctrl & avs_writedata[1]));

  always_comb begin
    status_next = core_status;
    if (cause_por) begin
      status_next = STATUS_POR | (core_status & STATUS_LOW3);
    end else if (cause_pin) begin
      status_next = core_status & STATUS_LOW5;
    end else if (cause_pin_wake) begin
      status_next = (core_status & STATUS_LOW3) | (8'h01 << BIT_TIMEOUT);
    end else if (cause_wdog) begin
      status_next = (core_status & STATUS_LOW3) | (8'h01 << BIT_POWERDOWN);
    end else if (cause_wdog_wake) begin
      status_next = core_status & STATUS_LOW3;
    end else begin
      // software may write bits 7:5 and 2:0; flags are read-only
      if (wr_status) begin
        status_next = (avs_writedata[7:0] & ~8'h18) | (core_status & 8'h18);
      end
      if (sleep_ev) begin
        status_next[BIT_TIMEOUT]   = 1'b1;
        status_next[BIT_POWERDOWN] = 1'b0;
      end
      // clear watchdog wins over sleep in the same cycle
      if (clrwd_ev) begin
        status_next[BIT_TIMEOUT]   = 1'b1;
        status_next[BIT_POWERDOWN] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    core_status <= status_next;
    if (any_reset) begin
      // all five causes load the same values here, except cause_reg which records the cause
      program_counter_low  <= PC_LOW_RST;
      port_direction_reg   <= DIR_RST;
      option_reg           <= OPTION_RST;
      // only the top bit is forced, the rest keeps its value
      indirect_pointer_reg <= indirect_pointer_reg | POINTER_TOP;
      cause_reg            <= {cause_wdog_wake, cause_wdog, cause_pin_wake,
                               cause_pin, cause_por};
    end else begin
      if (wr_pc_low) program_counter_low <= avs_writedata[7:0];
      if (wr_dir) port_direction_reg   <= avs_writedata[7:0];
      if (wr_opt) option_reg           <= avs_writedata[5:0];
      if (wr_ptr) indirect_pointer_reg <= avs_writedata[7:0];
    end
  end

  // ==========================================================
  // avalon read path: one wait cycle on reads, none on writes
  logic rd_ack_reg;
  logic [7:0] rd_mux;
  always_comb begin
    case (avs_address)
      OFF_STATUS:  rd_mux = core_status;
      OFF_PC_LOW:  rd_mux = program_counter_low;
      OFF_DIR:     rd_mux = port_direction_reg;
      OFF_OPTION:  rd_mux = {2'b00, option_reg};
      OFF_POINTER: rd_mux = indirect_pointer_reg;
      OFF_CAUSE:   rd_mux = {asleep_reg, startup_delay_timer_active, 1'b0, cause_reg};
      default:     rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ack_reg   <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack_reg <= avs_read & ~rd_ack_reg;
      if (avs_read & ~rd_ack_reg) begin
        avs_readdata <= {24'h00_0000, rd_mux};
      end
    end
  end
  assign avs_waitrequest = avs_read & ~rd_ack_reg;
endmodule : rst_seq
`default_nettype wire

// ---- testbench/rst_seq_props.sv ----
// Purpose : port-level checks of the reset sequencer
// Assumes : one clock, srst synchronous active high
// Notes   : bus writes are ignored in reset, so release shows reset values
`default_nettype none
module rst_seq_props (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       external_reset_pin_n,
  input wire logic       sleep_instr,
  input wire logic       clear_watchdog_instr,
  input wire logic       core_reset,
  input wire logic       osc_driver_on,
  input wire logic [7:0] program_counter_low,
  input wire logic [7:0] core_status,
  input wire logic [7:0] port_direction_reg,
  input wire logic [5:0] option_reg,
  input wire logic [7:0] indirect_pointer_reg,
  input wire logic       startup_delay_timer_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // checks
  AST_PIN_HOLD: assert property (!external_reset_pin_n [*6] |-> core_reset)
    else $error("pin low but core runs");
  AST_TIMER_HOLDS: assert property (startup_delay_timer_active |-> core_reset)
    else $error("timer active but core runs");
  AST_PCL_FF: assert property ($fell(core_reset) |-> program_counter_low == 8'hFF)
    else $error("program counter low not all ones");
  AST_DIR_OPT: assert property ($fell(core_reset) |->
    port_direction_reg == 8'hFF && option_reg == 6'h3F)
    else $error("direction or option not ones");
  AST_PTR_TOP: assert property ($fell(core_reset) |-> indirect_pointer_reg[7])
    else $error("pointer top bit clear");
  AST_POR_FLAGS: assert property ($fell(srst) |-> core_status[7:3] == 5'h03)
    else $error("power-on status wrong");
  AST_CLEAR_WDOG: assert property (clear_watchdog_instr && !core_reset &&
    external_reset_pin_n |=> core_status[4:3] == 2'h3)
    else $error("clear watchdog flags wrong");
  AST_SLEEP: assert property (sleep_instr && !core_reset && external_reset_pin_n |=>
    core_status[4:3] == 2'h2 && !osc_driver_on)
    else $error("sleep flags or oscillator wrong");
  cover property ($fell(core_reset));
  cover property (sleep_instr && !core_reset);
  cover property (clear_watchdog_instr && !core_reset);
endmodule // rst_seq_props
bind rst_seq rst_seq_props rst_seq_props_i (.clk, .srst, .external_reset_pin_n, .sleep_instr,
  .clear_watchdog_instr, .core_reset, .osc_driver_on, .program_counter_low, .core_status,
  .port_direction_reg, .option_reg, .indirect_pointer_reg, .startup_delay_timer_active);
`default_nettype wire

// ---- testbench/rst_partner.sv ----
// Purpose : reset pin driver and power-up circuitry model
// Assumes : requests from the bench arrive on clk
// Notes   : pin stays low until supply has settled for SETTLE cycles
`default_nettype none
module rst_partner #(
  parameter int unsigned SETTLE = 16
) (
  input wire logic clk,
  input wire logic power_good,
  input wire logic pin_req,
  input wire logic sag_req,
  output logic     power_up_event,
  output logic     external_reset_pin_n,
  output logic     supply_falling
);
  logic [7:0] settle_reg = 8'h00;
  logic       pin_reg    = 1'h0;
  logic       pwr_reg    = 1'h0;
  logic       sag_reg    = 1'h0;
  // ==========================================================
  // supply and pin
  always @(posedge clk) begin
    pwr_reg <= power_good;
    sag_reg <= sag_req;
    settle_reg <= !power_good ? 8'h00 : settle_reg + {7'h00, settle_reg != SETTLE[7:0]};
    pin_reg <= power_good && settle_reg == SETTLE[7:0] && !pin_req;
  end
  assign power_up_event       = pwr_reg;
  assign supply_falling       = sag_reg;
  assign external_reset_pin_n = pin_reg;
endmodule // rst_partner
`default_nettype wire

// ---- testbench/rst_seq_tb.sv ----
// Purpose : register-level test of the reset sequencer
// Assumes : startup count shortened to 8 rc edges, rc clock 8 clk period
// Notes   : low status bits written once, then followed through resets
`default_nettype none
module rst_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rst_pkg::*;
  logic clk = 1'h0, srst = 1'h1, pwr = 1'h0, pin_req = 1'h0, sag = 1'h0, wdog = 1'h0;
  logic rc_mode = 1'h0, slp = 1'h0, clrw = 1'h0, rd = 1'h0, wr = 1'h0, p;
  logic [7:0]  addr = 8'h00, q;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  rc_div = 4'h0;
  logic pue, sagf, pin_n, clkout, core_reset, osc_on, waitreq, tmr;
  logic [7:0] pc_low, status, dir, ptr;
  logic [5:0] opt;
  int errors = 0, samples_checked = 0, n;
  byte kinds[8] = '{1, 2, 1, 0, 3, 2, 0, 3};
  logic [7:0] st[8] = '{8'h0D, 8'h15, 8'h05, 8'h05, 8'h1D, 8'h15, 8'h15, 8'h1D};
  rst_cause_t ca[8] = '{CAUSE_WDOG, CAUSE_WDOG, CAUSE_WDOG_WAKE, CAUSE_PIN, CAUSE_PIN, CAUSE_PIN,
    CAUSE_PIN_WAKE, CAUSE_PIN_WAKE};
  always #5 clk = ~clk;
  always @(posedge clk) rc_div <= rc_div + 4'h1;
  rst_partner rst_partner_i (.clk(clk), .power_good(pwr), .pin_req(pin_req), .sag_req(sag),
    .power_up_event(pue), .external_reset_pin_n(pin_n), .supply_falling(sagf));
  rst_seq #(.STARTUP_COUNT(8)) rst_seq_i (.clk(clk), .srst(srst), .power_up_event(pue),
    .supply_falling(sagf), .external_reset_pin_n(pin_n), .watchdog_timeout(wdog),
    .timer_rc_clk(rc_div[2]), .osc_clk_in(rc_div[1]), .resistor_capacitor_osc_mode(rc_mode),
    .sleep_instr(slp), .clear_watchdog_instr(clrw), .clock_output_pin(clkout),
    .core_reset(core_reset), .osc_driver_on(osc_on), .program_counter_low(pc_low),
    .core_status(status), .port_direction_reg(dir), .option_reg(opt),
    .indirect_pointer_reg(ptr), .startup_delay_timer_active(tmr), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(waitreq));
  // ==========================================================
  // tasks
  task automatic stop_test();
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    n = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h00_0000, d};
    @(posedge clk);
    while (waitreq !== 1'h0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) errors++;
    q = rdata[7:0];
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge clk);
  endtask
  // waits for a reset to start, then for it to end; n counts clk edges
  task automatic settle();
    n = 0;
    while (core_reset !== 1'h1 && n < 50) begin n++; @(posedge clk); end
    if (n == 50) errors++;
    while (core_reset !== 1'h0 && n < 600) begin n++; @(posedge clk); end
    if (n == 600) errors++;
  endtask
  task automatic ev(input byte k);
    if (k == 1) wdog <= 1'h1;
    else if (k == 0) pin_req <= 1'h1;
    else if (k == 2) slp <= 1'h1;
    else clrw <= 1'h1;
    repeat (k > 1 ? 1 : 8) @(posedge clk);
    {wdog, pin_req, slp, clrw} <= 4'h0;
    if (k < 2) settle();
    repeat (6) @(posedge clk);
  endtask
  // ==========================================================
  // sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    pwr <= 1'h1;
    settle();
    bus(0, OFF_STATUS, 8'h00); chk("por status", q & 8'hF8, STATUS_POR);
    bus(0, OFF_PC_LOW, 8'h00);
    chk("pc low", q, PC_LOW_RST);
    bus(0, OFF_DIR, 8'h00); chk("direction", q, DIR_RST);
    bus(0, OFF_OPTION, 8'h00); chk("option", q, {2'h0, OPTION_RST});
    bus(0, OFF_POINTER, 8'h00); chk("pointer top", q & POINTER_TOP, POINTER_TOP);
    bus(0, 8'h3C, 8'h00); chk("unmapped", q, 8'h00);
    bus(1, OFF_STATUS, 8'hE5);
    // spoil the reset-loaded registers so the later resets must restore all but the pointer's low bits
    bus(1, OFF_PC_LOW, 8'h12);
    bus(1, OFF_DIR, 8'h00);
    bus(1, OFF_OPTION, 8'h00);
    bus(1, OFF_POINTER, 8'h01);
    for (int i = 0; i < 8; i++) begin
      ev(kinds[i]);
      bus(0, OFF_STATUS, 8'h00);
      chk("status", q, st[i]);
      bus(0, OFF_CAUSE, 8'h00); chk("cause", q & 8'h9F, {kinds[i] == 2, 2'h0, ca[i]});
    end
    pin_req <= 1'h1;
    repeat (8) @(posedge clk);
    bus(1, OFF_STATUS, 8'h02);
    pin_req <= 1'h0;
    settle(); chk("delay", {7'h00, n >= 56 && n <= 84}, 8'h01);
    bus(0, OFF_STATUS, 8'h00);
    chk("pin keeps", q, 8'h1D);
    chk("status port", status, 8'h1D);
    chk("pc low port", pc_low, PC_LOW_RST);
    chk("direction port", dir, DIR_RST);
    chk("option port", {2'h0, opt}, {2'h0, OPTION_RST});
    chk("pointer kept", ptr, 8'h81);
    sag <= 1'h1;
    repeat (4) @(posedge clk);
    sag <= 1'h0;
    repeat (4) @(posedge clk); chk("sag", {7'h00, core_reset}, 8'h00);
    rc_mode <= 1'h1;
    repeat (40) @(posedge clk);
    n = 0;
    p = clkout;
    repeat (64) begin
      @(posedge clk);
      if (clkout === 1'h1 && p === 1'h0) n++;
      p = clkout;
    end
    chk("clock out rises", n[7:0], 8'h04);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule // rst_seq_tb
`default_nettype wire
